// File: common/nvmac_pkg.sv
/*
  nvmac_pkg: register map, field positions, reset values and timing for the
  nonvolatile access control block.
  Assumes a 10 MHz system clock and a 32-bit classic Wishbone register bus.
*/
package nvmac_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL = 4'h0;  // nvm_control_one
  localparam logic [3:0] OFS_STS  = 4'h4;  // sticky event status, write one to clear
  localparam logic [3:0] OFS_MASK = 4'h8;  // event mask, same layout

  // ----------------------------------------------------------------
  // nvm_control_one field positions
  // ----------------------------------------------------------------
  localparam int B_FLASH  = 7;  // flash_vs_eeprom_select
  localparam int B_SETUP  = 6;  // setup_space_select
  localparam int B_UNUSED = 5;  // always reads zero
  localparam int B_ERASE  = 4;  // row erase select
  localparam int B_ABORT  = 3;  // cycle_abort_flag
  localparam int B_ALLOW  = 2;  // nvm_change_allow
  localparam int B_PROG   = 1;  // program launch
  localparam int B_READ   = 0;  // read launch

  // ----------------------------------------------------------------
  // event bits and reset values
  // ----------------------------------------------------------------
  localparam int EV_DONE  = 0;  // program cycle completed
  localparam int EV_ABORT = 1;  // program cycle aborted or refused
  localparam int EV_READ  = 2;  // read issued
  localparam int EV_W     = 3;
  localparam logic [7:0]      CTRL_RST = 8'h00;
  localparam logic [EV_W-1:0] EV_RST   = 3'h0;

  // ----------------------------------------------------------------
  // target space codes
  // ----------------------------------------------------------------
  localparam logic [1:0] TGT_EEPROM = 2'h0;
  localparam logic [1:0] TGT_FLASH  = 2'h1;
  localparam logic [1:0] TGT_SETUP  = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ      = 10000;
  localparam int PROG_TIME_US = 4000;  // self-timed program cycle length
  localparam int PROG_CYCLES  = (PROG_TIME_US * CLK_KHZ) / 1000;
  localparam int CNT_W        = 16;

  // control state, gray along idle -> program -> idle
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PROG = 2'b01,
    ST_READ = 2'b10
  } nvmac_state_e;

endpackage : nvmac_pkg

// File: design/nvmac_cycle_timer.sv
/*
  nvmac_cycle_timer: counts one self-timed program cycle.
  Assumes start is a one-cycle pulse given only while not busy; abort ends the
  cycle at once without a done pulse.
*/
`timescale 1ns/100ps
module nvmac_cycle_timer #(
  parameter int          CNT_W  = 16,
  parameter logic [15:0] CYCLES = 16'h9C40
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic ce,
  // control
  input  wire logic start,
  input  wire logic abort,
  // status
  output logic      busy,
  output logic      done
);

  logic [CNT_W-1:0] count;

  wire lastTick = busy && (count == CNT_W'(1));

  // count down from the cycle length; done fires on the final tick
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      busy  <= 1'b0;
      done  <= 1'b0;
      count <= '0;
    end else if (ce) begin
      done <= lastTick && !abort;
      if (abort) begin
        busy  <= 1'b0;
        count <= '0;
      end else if (start && !busy) begin
        busy  <= 1'b1;
        count <= CNT_W'(CYCLES);
      end else if (busy) begin
        busy  <= !lastTick;
        count <= count - CNT_W'(1);
      end
    end
  end

endmodule : nvmac_cycle_timer

// File: design/nvmac_top.sv
/*
  nvmac_top: control register, launch sequencing and event reporting for
  self-timed access to data EEPROM, flash program memory and setup space.
  Assumes a 10 MHz ref_clk, a classic Wishbone master, and an array that
  follows the target, erase and pulse outputs; warmRst flags any reset other
  than power-on, synchronous to ref_clk.
*/
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
module nvmac_top #(
  parameter int PROG_CYCLES = nvmac_pkg::PROG_CYCLES
) (
  // clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        warmRst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // array side
  output logic      [1:0]  targetSpace,
  output logic             eraseRow,
  output logic             progBusy,
  output logic             readPulse,
  // interrupt
  output logic             irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic                     flashSel;
  logic                     setupSel;
  logic                     eraseSel;
  logic                     abortFlag;
  logic                     allow;
  logic                     progGo;
  logic                     readGo;
  logic [nvmac_pkg::EV_W-1:0] evSts;
  logic [nvmac_pkg::EV_W-1:0] evMask;
  nvmac_pkg::nvmac_state_e  state;
  nvmac_pkg::nvmac_state_e  next_state;
  logic                     timerDone;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire       access  = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  wire       wrLow   = access && wb_we_i && wb_sel_i[0];
  wire       hitCtrl = (wb_adr_i == nvmac_pkg::OFS_CTRL);
  wire       hitSts  = (wb_adr_i == nvmac_pkg::OFS_STS);
  wire       hitMask = (wb_adr_i == nvmac_pkg::OFS_MASK);
  wire       wrCtrl  = wrLow && hitCtrl;
  wire       wrSts   = wrLow && hitSts;
  wire       wrMask  = wrLow && hitMask;
  wire [7:0] wd      = wb_dat_i[7:0];
  wire       busy    = (state == nvmac_pkg::ST_PROG);

  // control image; the unused position is tied low
  wire [7:0] ctrlImage = {flashSel, setupSel, 1'b0, eraseSel,
                          abortFlag, allow, progGo, readGo};

  // read mux, unmapped addresses answer zero
  wire [7:0] rdByte;
  assign rdByte = hitCtrl ? ctrlImage :
                  hitSts  ? {5'h00, evSts} :
                  hitMask ? {5'h00, evMask} : 8'h00;

  // ----------------------------------------------------------------
  // launch qualification
  // ----------------------------------------------------------------
  // selects cannot move under a running cycle, so they stay as written
  wire nextFlash = (wrCtrl && !busy) ? wd[nvmac_pkg::B_FLASH] : flashSel;
  wire nextSetup = (wrCtrl && !busy) ? wd[nvmac_pkg::B_SETUP] : setupSel;
  wire askProg   = wrCtrl && !busy && wd[nvmac_pkg::B_PROG];
  wire askRead   = wrCtrl && !busy && wd[nvmac_pkg::B_READ] && !askProg;
  // allow must already stand before the launch write
  wire launchOk  = askProg && allow && !warmRst;
  wire launchBad = askProg && !allow && !warmRst;
  wire readOk    = askRead && !nextFlash && !nextSetup && !warmRst;
  wire warmAbort = warmRst && busy;
  wire evAbort   = launchBad || warmAbort;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // plain case over the control states
  always_comb begin
    next_state = state;
    case (state)
      nvmac_pkg::ST_IDLE: begin
        if (launchOk) begin
          next_state = nvmac_pkg::ST_PROG;
        end else if (readOk) begin
          next_state = nvmac_pkg::ST_READ;
        end
      end
      nvmac_pkg::ST_PROG: begin
        if (warmRst || timerDone) begin
          next_state = nvmac_pkg::ST_IDLE;
        end
      end
      nvmac_pkg::ST_READ: begin
        next_state = nvmac_pkg::ST_IDLE;
      end
      default: begin
        next_state = nvmac_pkg::ST_IDLE;
      end
    endcase
  end

  // self-timed program cycle length
  nvmac_cycle_timer #(
    .CNT_W  (nvmac_pkg::CNT_W),
    .CYCLES (16'(PROG_CYCLES))
  ) u_timer (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .ce      (ce),
    .start   (launchOk),
    .abort   (warmRst),
    .busy    (progBusy),
    .done    (timerDone)
  );

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // power-on clears everything; a warm reset keeps the selects for tracing
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      {flashSel, setupSel, eraseSel, abortFlag} <= 4'h0;
      {allow, progGo, readGo} <= 3'h0;
      state <= nvmac_pkg::ST_IDLE;
    end else if (ce) begin
      state    <= next_state;
      flashSel <= nextFlash;
      setupSel <= nextSetup;
      readGo   <= readOk;
      if (warmRst) begin
        eraseSel <= 1'b0;
        allow    <= 1'b0;
        progGo   <= 1'b0;
      end else begin
        if (wrCtrl) begin
          allow <= wd[nvmac_pkg::B_ALLOW];
        end
        if (timerDone) begin
          eraseSel <= 1'b0;
          progGo   <= 1'b0;
        end else if (wrCtrl && !busy) begin
          eraseSel <= wd[nvmac_pkg::B_ERASE];
          progGo   <= launchOk;
        end
      end
      // raising wins over a software write of the flag
      if (evAbort) begin
        abortFlag <= 1'b1;
      end else if (timerDone) begin
        abortFlag <= 1'b0;
      end else if (wrCtrl) begin
        abortFlag <= wd[nvmac_pkg::B_ABORT];
      end
    end
  end

  // ----------------------------------------------------------------
  // events and interrupt
  // ----------------------------------------------------------------
  wire [nvmac_pkg::EV_W-1:0] evSet = {readOk, evAbort, timerDone};
  wire [nvmac_pkg::EV_W-1:0] evClr = wrSts ? wd[nvmac_pkg::EV_W-1:0] : '0;
  wire [nvmac_pkg::EV_W-1:0] next_evSts = (evSts & ~evClr) | evSet;
  wire [nvmac_pkg::EV_W-1:0] next_evMask =
    wrMask ? wd[nvmac_pkg::EV_W-1:0] : evMask;

  // a set arriving with its clear survives the clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      evSts  <= nvmac_pkg::EV_RST;
      evMask <= nvmac_pkg::EV_RST;
      irq    <= 1'b0;
    end else if (ce) begin
      evSts  <= next_evSts;
      evMask <= next_evMask;
      irq    <= |(next_evSts & next_evMask);
    end
  end

  // ----------------------------------------------------------------
  // bus answer and array outputs
  // ----------------------------------------------------------------
  // one registered answer a clock after the strobe; ack drops the cycle after it was given
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o    <= 1'b0;
      wb_dat_o    <= 32'h0000_0000;
      targetSpace <= nvmac_pkg::TGT_EEPROM;
      eraseRow    <= 1'b0;
      readPulse   <= 1'b0;
    end else if (ce) begin
      wb_ack_o  <= access;
      eraseRow  <= eraseSel;
      readPulse <= readOk;
      if (access && !wb_we_i) begin
        wb_dat_o <= {24'h00_0000, rdByte};
      end
      if (nextSetup) begin
        targetSpace <= nvmac_pkg::TGT_SETUP;
      end else if (nextFlash) begin
        targetSpace <= nvmac_pkg::TGT_FLASH;
      end else begin
        targetSpace <= nvmac_pkg::TGT_EEPROM;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  bit_five_zero_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (wb_ack_o && $past(hitCtrl) && $past(!wb_we_i)) |-> (wb_dat_o[5] == 1'b0))
    else $error("control bit five read back as one");

  launch_blocked_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (askProg && !allow && !warmRst) |=> (!progGo && abortFlag && !progBusy))
    else $error("launch taken without change allow");

  launch_starts_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    launchOk |=> (progGo && progBusy && state == nvmac_pkg::ST_PROG))
    else $error("launch did not start a cycle");

  prog_sticky_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (progGo && !timerDone && !warmRst) |=> progGo)
    else $error("program launch dropped without completion");

  read_one_cycle_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (readGo && ce) |=> !readGo)
    else $error("read launch held longer than one cycle");

  read_guard_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $rose(readGo) |-> (!flashSel && !setupSel && readPulse))
    else $error("read launch set with flash or setup selected");

  done_clears_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (timerDone && ce && !warmRst) |=> (!eraseSel && !progGo && !abortFlag))
    else $error("completion left erase, launch or abort set");

  warm_abort_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (warmRst && busy && ce) |=> (abortFlag && !progGo && !progBusy)[*1])
    else $error("reset during cycle did not raise abort");

  select_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $rose(abortFlag) |-> ($stable(flashSel) && $stable(setupSel)))
    else $error("target select changed when abort raised");

  target_map_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (ce && setupSel) |=> (targetSpace == nvmac_pkg::TGT_SETUP || !setupSel))
    else $error("setup select did not override flash select");

  flash_target_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (flashSel && !setupSel) |-> (targetSpace == nvmac_pkg::TGT_FLASH))
    else $error("flash select did not steer the array to flash");

  read_target_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    readPulse |-> (targetSpace == nvmac_pkg::TGT_EEPROM))
    else $error("read pulse issued while not aimed at data eeprom");

  allow_gate_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    $rose(progBusy) |-> $past(allow))
    else $error("program cycle started without change allow");

  warm_selects_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (warmRst && ce && !wrCtrl) |=> ($stable(flashSel) && $stable(setupSel)))
    else $error("warm reset disturbed the target selects");

  erase_follow_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    ce |=> (eraseRow == $past(eraseSel)))
    else $error("erase output did not follow the erase select");

  // ----------------------------------------------------------------
  // cycle length helper
  // ----------------------------------------------------------------
  // a repetition count this long would choke the tools, so count it here
  localparam int LEN_W = nvmac_pkg::CNT_W;
  logic [LEN_W-1:0] busyLen;

  // clocks spent busy in the running cycle; frozen with the timer by ce
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      busyLen <= '0;
    end else if (ce) begin
      busyLen <= progBusy ? busyLen + LEN_W'(1) : '0;
    end
  end

  busy_end_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    ($fell(progBusy) && !$past(warmRst)) |-> timerDone)
    else $error("program cycle ended without a completion pulse");

  cycle_length_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    ($fell(progBusy) && !$past(warmRst)) |-> (busyLen == LEN_W'(PROG_CYCLES)))
    else $error("program cycle length differs from the set count");

endmodule : nvmac_top

// File: sim/tb.sv
/*
  tb: self-checking bench for nvmac_top, one task per scenario.
  Assumes the register map of nvmac_pkg, a 10 MHz ref_clk and a
  shortened program cycle of 20 clocks.
*/
`timescale 1ns/100ps
module tb;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int P = 20;  // short cycle keeps the run brief
  logic        ref_clk, rstn, ce, warmRst;
  logic        wbCyc, wbStb, wbWe;
  logic [3:0]  wbAdr, wbSel;
  logic [31:0] wbDat, wbDatO, q;
  logic        wbAck, eraseRow, progBusy, readPulse, irq;
  logic [1:0]  targetSpace;
  int          failCount, checksDone, pulseCnt, busyCnt;

  nvmac_top #(.PROG_CYCLES(P)) i_dut (
    .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .warmRst(warmRst),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel), .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .targetSpace(targetSpace), .eraseRow(eraseRow), .progBusy(progBusy),
    .readPulse(readPulse), .irq(irq));

  // ----------------------------------------------------------------
  // clock, pulse counters, watchdog
  // ----------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // pre-edge values are seen here, so no race with the design flops
  always @(posedge ref_clk) begin
    if (readPulse === 1'b1) pulseCnt++;
    if (progBusy === 1'b1) busyCnt++;
  end
  initial begin
    #2000000;
    failCount++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // one classic cycle; waits up to 50 clocks for ack, then fails the ack check
  task automatic xfer(input logic we, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge ref_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe  <= we;
    wbAdr <= a;
    wbDat <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    q = wbDatO;
    if (n >= 50) check("ack", 32'h1, 32'h0);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
  endtask : xfer

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    check(what, exp, q);
  endtask : rd_chk

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd_chk("ctrl reset", nvmac_pkg::OFS_CTRL, 32'h0);
    rd_chk("status reset", nvmac_pkg::OFS_STS, 32'h0);
    rd_chk("mask reset", nvmac_pkg::OFS_MASK, 32'h0);
    xfer(1'b1, 4'hC, 32'hFF);
    rd_chk("unmapped", 4'hC, 32'h0);
    xfer(1'b1, nvmac_pkg::OFS_CTRL, 32'h20);
    rd_chk("unused bit", nvmac_pkg::OFS_CTRL, 32'h0);
    // a write without its low byte lane enabled must leave control alone
    wbSel <= 4'hE;
    xfer(1'b1, nvmac_pkg::OFS_CTRL, 32'h04);
    wbSel <= 4'hF;
    rd_chk("lane zero off", nvmac_pkg::OFS_CTRL, 32'h0);
  endtask : t_reset

  task automatic t_read();
    pulseCnt = 0;
    xfer(1'b1, nvmac_pkg::OFS_CTRL, 32'h01);
    rd_chk("read self clear", nvmac_pkg::OFS_CTRL, 32'h0);
    check("read pulses", 32'h1, pulseCnt);
    rd_chk("read event", nvmac_pkg::OFS_STS, 32'h4);
    xfer(1'b1, nvmac_pkg::OFS_CTRL, 32'h81);
    rd_chk("flash refuses read", nvmac_pkg::OFS_CTRL, 32'h80);
    xfer(1'b1, nvmac_pkg::OFS_CTRL, 32'h41);
    rd_chk("setup refuses read", nvmac_pkg::OFS_CTRL, 32'h40);
    check("no extra pulse", 32'h1, pulseCnt);
    xfer(1'b1, nvmac_pkg::OFS_STS, 32'h7);
  endtask : t_read

  task automatic t_noallow();
    busyCnt = 0;
    xfer(1'b1, nvmac_pkg::OFS_CTRL, 32'h00);
    xfer(1'b1, nvmac_pkg::OFS_CTRL, 32'h02);
    rd_chk("blocked launch", nvmac_pkg::OFS_CTRL, 32'h08);
    check("no busy", 32'h0, busyCnt);
    rd_chk("abort event", nvmac_pkg::OFS_STS, 32'h2);
  endtask : t_noallow

  task automatic t_prog();
    int n = 0;
    xfer(1'b1, nvmac_pkg::OFS_CTRL, 32'h94);
    busyCnt = 0;
    xfer(1'b1, nvmac_pkg::OFS_CTRL, 32'h96);
    check("busy", 32'h1, progBusy);
    check("erase out", 32'h1, eraseRow);
    check("flash target", 32'(nvmac_pkg::TGT_FLASH), 32'(targetSpace));
    xfer(1'b1, nvmac_pkg::OFS_CTRL, 32'h94);
    rd_chk("launch not cleared", nvmac_pkg::OFS_CTRL, 32'h96);
    // software polls for the hardware clear
    do begin
      xfer(1'b0, nvmac_pkg::OFS_CTRL, 32'h0);
      n++;
    end while (q[nvmac_pkg::B_PROG] !== 1'b0 && n < 100);
    rd_chk("after cycle", nvmac_pkg::OFS_CTRL, 32'h84);
    check("cycle length", P, busyCnt);
    rd_chk("done event", nvmac_pkg::OFS_STS, 32'h3);
    xfer(1'b1, nvmac_pkg::OFS_STS, 32'h7);
  endtask : t_prog

  task automatic t_abort();
    xfer(1'b1, nvmac_pkg::OFS_CTRL, 32'hC4);
    check("setup target", 32'(nvmac_pkg::TGT_SETUP), 32'(targetSpace));
    xfer(1'b1, nvmac_pkg::OFS_CTRL, 32'hC6);
    @(posedge ref_clk);
    warmRst <= 1'b1;
    @(posedge ref_clk);
    warmRst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check("busy ends", 32'h0, progBusy);
    rd_chk("abort keeps selects", nvmac_pkg::OFS_CTRL, 32'hC8);
  endtask : t_abort

  task automatic t_irq();
    xfer(1'b1, nvmac_pkg::OFS_MASK, 32'h2);
    @(posedge ref_clk);
    check("irq raised", 32'h1, irq);
    xfer(1'b1, nvmac_pkg::OFS_MASK, 32'h0);
    @(posedge ref_clk);
    check("irq masked", 32'h0, irq);
    xfer(1'b1, nvmac_pkg::OFS_MASK, 32'h2);
    xfer(1'b1, nvmac_pkg::OFS_STS, 32'h7);
    @(posedge ref_clk);
    check("irq cleared", 32'h0, irq);
    rd_chk("status cleared", nvmac_pkg::OFS_STS, 32'h0);
  endtask : t_irq

  // ----------------------------------------------------------------
  // verdict and main sequence
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("mismatches %0d checks %0d", failCount, checksDone);
    if (failCount == 0 && checksDone > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  initial begin
    failCount  = 0;
    checksDone = 0;
    pulseCnt   = 0;
    busyCnt    = 0;
    rstn       = 1'b0;
    ce         = 1'b1;
    warmRst    = 1'b0;
    wbCyc      = 1'b0;
    wbStb      = 1'b0;
    wbWe       = 1'b0;
    wbAdr      = 4'h0;
    wbSel      = 4'hF;
    wbDat      = 32'h0;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset();
    t_read();
    t_noallow();
    t_prog();
    t_abort();
    t_irq();
    end_sim();
  end
endmodule : tb
